/* hw/uss_cfg.svh */
// Register offsets, field positions and reset values of the serial slave
`ifndef USS_CFG_SVH
`define USS_CFG_SVH

////////////////////////////////////////////////////////////////////////
// Register offsets (3-bit address)
`define USS_ADDR_RX_STATUS_CONTROL 3'h0
`define USS_ADDR_TX_DATA           3'h1
`define USS_ADDR_TX_STATUS_CONTROL 3'h2
`define USS_ADDR_RX_DATA           3'h3
`define USS_ADDR_IRQ_ENABLE        3'h4
`define USS_ADDR_IRQ_FLAGS         3'h5

////////////////////////////////////////////////////////////////////////
// rx_status_control fields
`define USS_RCS_SERIAL_PORT_EN     7
`define USS_RCS_NINTH_RX_EN        6
`define USS_RCS_SINGLE_RX_EN       5
`define USS_RCS_CONT_RX_EN         4
`define USS_RCS_ADDR_DETECT_EN     3
`define USS_RCS_FRAMING_ERR        2
`define USS_RCS_OVERRUN            1
`define USS_RCS_RX_NINTH_BIT       0
`define USS_RCS_WR_MASK            8'hf8

////////////////////////////////////////////////////////////////////////
// tx_status_control fields
`define USS_TCS_CLOCK_SOURCE_SEL   7
`define USS_TCS_NINTH_TX_EN        6
`define USS_TCS_TRANSMIT_EN        5
`define USS_TCS_SYNC_MODE          4
`define USS_TCS_HIGH_RATE_SEL      2
`define USS_TCS_SHIFT_EMPTY        1
`define USS_TCS_TX_NINTH_BIT       0
`define USS_TCS_WR_MASK            8'hf5

////////////////////////////////////////////////////////////////////////
// irq_enable and irq_flags fields
`define USS_IEN_GLOBAL             7
`define USS_IEN_PERIPHERAL         6
`define USS_IEN_RX                 5
`define USS_IEN_TX                 4
`define USS_IFL_RX                 5
`define USS_IFL_TX                 4

////////////////////////////////////////////////////////////////////////
// Reset values and bit counts
`define USS_RST_RX_STATUS_CONTROL  8'h00
`define USS_RST_TX_STATUS_CONTROL  8'h02
`define USS_RST_TX_DATA            8'h00
`define USS_RST_RX_DATA            8'h00
`define USS_RST_IRQ_ENABLE         8'h00
`define USS_BITS_SHORT             4'h8
`define USS_BITS_LONG              4'h9
`define USS_RX_DEPTH               2

`endif

/* hw/uss_pkg.sv */
// Types shared by the serial slave design
package uss_pkg;
  typedef enum logic [1:0] {
    USS_MODE_OFF,
    USS_MODE_TX,
    USS_MODE_RX
  } uss_mode_t;
endpackage

/* hw/uss_rx_fifo.sv */
// Small receive buffer with registered head data
`timescale 1ns/1ps
module uss_rx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] top,
  output logic                  empty,
  output logic                  full
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + AW'(1));
  endfunction

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic [AW-1:0]    rd_next;
  logic [WIDTH-1:0] head_d;
  logic [WIDTH-1:0] top_q;

  ////////////////////////////////////////////////////////////////////////
  // Head is computed ahead so a read right after a push sees new data
  assign rd_next = pop ? nxt(rd_ptr_q) : rd_ptr_q;
  assign head_d  = (push && wr_ptr_q == rd_next) ? wdata : mem_q[rd_next];
  assign cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign empty   = (cnt_q == '0);
  assign full    = (cnt_q == (AW+1)'(DEPTH));
  assign top     = top_q;

  for (genvar gi = 0; gi < DEPTH; gi++) begin : g_mem
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
        mem_q[gi] <= '0;
      else if (push && wr_ptr_q == AW'(gi))
        mem_q[gi] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      top_q    <= '0;
    end else begin
      wr_ptr_q <= push ? nxt(wr_ptr_q) : wr_ptr_q;
      rd_ptr_q <= rd_next;
      cnt_q    <= cnt_d;
      top_q    <= head_d;
    end
  end
endmodule

/* hw/uss_core.sv */
// Synchronous slave serial transceiver with sleep-time operation
`timescale 1ns/1ps
`include "uss_cfg.svh"

module uss_core #(
  parameter int RX_DEPTH = `USS_RX_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       core_sleep,
  input  wire logic       serial_clock_pin,
  input  wire logic       serial_data_pin_in,
  output logic            serial_data_pin_out,
  output logic            serial_data_pin_oe,
  output logic            irq_request,
  output logic            wake_request,
  output logic            irq_vector_request
);

  function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [7:0] rcs_q;
  logic [7:0] tcs_q;
  logic [7:0] ien_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_sel;
  logic       wr_rcs;
  logic       wr_tcs;
  logic       wr_ien;
  logic       wr_txd;
  logic       rd_rxd;

  assign wr_rcs = reg_wr & hit(reg_addr, `USS_ADDR_RX_STATUS_CONTROL);
  assign wr_tcs = reg_wr & hit(reg_addr, `USS_ADDR_TX_STATUS_CONTROL);
  assign wr_ien = reg_wr & hit(reg_addr, `USS_ADDR_IRQ_ENABLE);
  assign wr_txd = reg_wr & hit(reg_addr, `USS_ADDR_TX_DATA);
  assign rd_rxd = reg_rd & hit(reg_addr, `USS_ADDR_RX_DATA);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rcs_q <= `USS_RST_RX_STATUS_CONTROL;
      tcs_q <= `USS_RST_TX_STATUS_CONTROL & `USS_TCS_WR_MASK;
      ien_q <= `USS_RST_IRQ_ENABLE;
    end else begin
      if (wr_rcs)
        rcs_q <= reg_wdata & `USS_RCS_WR_MASK;
      if (wr_tcs)
        tcs_q <= reg_wdata & `USS_TCS_WR_MASK;
      if (wr_ien)
        ien_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic               port_en;
  logic               cont_rx_en;
  logic               rx9_en;
  logic               tx9_en;
  logic               tx_en;
  logic               slave_on;
  uss_pkg::uss_mode_t mode;
  logic               tx_mode;
  logic               rx_mode;

  assign port_en    = rcs_q[`USS_RCS_SERIAL_PORT_EN];
  assign cont_rx_en = rcs_q[`USS_RCS_CONT_RX_EN];
  assign rx9_en     = rcs_q[`USS_RCS_NINTH_RX_EN];
  assign tx9_en     = tcs_q[`USS_TCS_NINTH_TX_EN];
  assign tx_en      = tcs_q[`USS_TCS_TRANSMIT_EN];
  // All slave logic is clocked by ref_clk, so slave runs on in sleep while ref_clk runs
  assign slave_on   = tcs_q[`USS_TCS_SYNC_MODE] & port_en &
                      ~tcs_q[`USS_TCS_CLOCK_SOURCE_SEL];
  assign mode = !slave_on ? uss_pkg::USS_MODE_OFF :
                (rcs_q[`USS_RCS_SINGLE_RX_EN] | cont_rx_en) ?
                uss_pkg::USS_MODE_RX : uss_pkg::USS_MODE_TX;

  always_comb begin
    tx_mode = 1'b0;
    rx_mode = 1'b0;
    case (mode)
      uss_pkg::USS_MODE_TX: tx_mode = 1'b1;
      uss_pkg::USS_MODE_RX: rx_mode = 1'b1;
      default: begin
        tx_mode = 1'b0;
        rx_mode = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level counts once stages two and three agree
  logic [1:0] pin_raw;
  logic [2:0] sync_q [2];
  logic [1:0] filt_q;
  logic [1:0] filt_d;
  logic       ck_rise;
  logic       ck_fall;
  logic       dt_now;

  assign pin_raw = {serial_data_pin_in, serial_clock_pin};

  for (genvar gi = 0; gi < 2; gi++) begin : g_sync
    assign filt_d[gi] = (sync_q[gi][1] == sync_q[gi][2]) ?
                        sync_q[gi][2] : filt_q[gi];
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        sync_q[gi] <= 3'h0;
        filt_q[gi] <= 1'b0;
      end else begin
        sync_q[gi] <= {sync_q[gi][1:0], pin_raw[gi]};
        filt_q[gi] <= filt_d[gi];
      end
    end
  end

  // Link clock edges drive both shifters, never the system timing
  assign ck_rise = filt_d[0] & ~filt_q[0];
  assign ck_fall = ~filt_d[0] & filt_q[0];
  assign dt_now  = filt_d[1];

  ////////////////////////////////////////////////////////////////////////
  // Transmit path
  logic [8:0] hold_q;
  logic       hold_full_q;
  logic [8:0] tsr_q;
  logic       tsr_full_q;
  logic [3:0] tx_cnt_q;
  logic       dout_q;
  logic       oe_q;
  logic       tx_active;
  logic [3:0] tx_nbits;
  logic       tx_done;
  logic       load_tsr;
  logic       tx_flag;

  assign tx_active = tx_mode & tx_en;
  assign tx_nbits  = tx9_en ? `USS_BITS_LONG : `USS_BITS_SHORT;
  // Master gives exactly one clock per bit, so done on last fall
  assign tx_done   = tx_active & tsr_full_q & ck_fall &
                     (tx_cnt_q == tx_nbits);
  assign load_tsr  = tx_active & hold_full_q &
                     (~tsr_full_q | tx_done);
  assign tx_flag   = tx_en & ~hold_full_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q      <= 9'h000;
      hold_full_q <= 1'b0;
    end else if (!port_en) begin
      hold_full_q <= 1'b0;
    end else if (load_tsr) begin
      hold_full_q <= 1'b0;
    end else if (wr_txd && !hold_full_q) begin
      hold_q      <= {tcs_q[`USS_TCS_TX_NINTH_BIT], reg_wdata};
      hold_full_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tsr_q      <= 9'h000;
      tsr_full_q <= 1'b0;
      tx_cnt_q   <= 4'h0;
      dout_q     <= 1'b0;
    end else if (!tx_active) begin
      tsr_full_q <= 1'b0;
      tx_cnt_q   <= 4'h0;
    end else if (load_tsr) begin
      tsr_q      <= hold_q;
      tsr_full_q <= 1'b1;
      tx_cnt_q   <= 4'h0;
    end else if (tx_done) begin
      tsr_full_q <= 1'b0;
      tx_cnt_q   <= 4'h0;
    end else if (tsr_full_q && ck_rise && tx_cnt_q != tx_nbits) begin
      dout_q   <= tsr_q[0];
      tsr_q    <= {1'b0, tsr_q[8:1]};
      tx_cnt_q <= tx_cnt_q + 4'h1;
    end
  end

  // Output driver only in slave transmit mode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      oe_q <= 1'b0;
    else
      oe_q <= tx_active;
  end

  assign serial_data_pin_out = dout_q;
  assign serial_data_pin_oe  = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Receive path
  logic [8:0] rsr_q;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_cnt_inc;
  logic [3:0] rx_nbits;
  logic       ovr_q;
  logic       rx_active;
  logic       rx_done;
  logic [8:0] rx_word;
  logic       fifo_push;
  logic       fifo_pop;
  logic       fifo_empty;
  logic       fifo_full;
  logic [8:0] fifo_top;
  logic       rx_flag;

  // Single enable alone never starts a slave word
  assign rx_active  = rx_mode & cont_rx_en & ~ovr_q;
  assign rx_nbits   = rx9_en ? `USS_BITS_LONG : `USS_BITS_SHORT;
  assign rx_cnt_inc = rx_cnt_q + 4'h1;
  assign rx_done    = rx_active & ck_fall & (rx_cnt_inc == rx_nbits);
  assign rx_word    = rx9_en ? {dt_now, rsr_q[8:1]} :
                      {1'b0, dt_now, rsr_q[8:2]};
  assign fifo_push  = rx_done & ~fifo_full;
  assign fifo_pop   = rd_rxd & ~fifo_empty;
  assign rx_flag    = ~fifo_empty;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rsr_q    <= 9'h000;
      rx_cnt_q <= 4'h0;
    end else if (!rx_active) begin
      rx_cnt_q <= 4'h0; // Partial word dropped
    end else if (ck_fall) begin
      rsr_q    <= {dt_now, rsr_q[8:1]};
      rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_inc;
    end
  end

  // Overrun blocks reception; only dropping the continuous or port enable clears it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      ovr_q <= 1'b0;
    else if (!cont_rx_en || !port_en)
      ovr_q <= 1'b0;
    else if (rx_done && fifo_full)
      ovr_q <= 1'b1;
  end

  uss_rx_fifo #(
    .WIDTH (9),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .push    (fifo_push),
    .wdata   (rx_word),
    .pop     (fifo_pop),
    .top     (fifo_top),
    .empty   (fifo_empty),
    .full    (fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read mux; ninth bit sits in status, so read it before the data
  logic [7:0] rcs_rd;
  logic [7:0] tcs_rd;
  logic [7:0] ifl_rd;

  assign rcs_rd = {rcs_q[7:3], 1'b0, ovr_q, fifo_top[8]};
  assign tcs_rd = {tcs_q[7:2], ~tsr_full_q, tcs_q[0]};
  assign ifl_rd = {2'h0, rx_flag, tx_flag, 4'h0};

  always_comb begin
    case (reg_addr)
      `USS_ADDR_RX_STATUS_CONTROL: rd_sel = rcs_rd;
      `USS_ADDR_TX_STATUS_CONTROL: rd_sel = tcs_rd;
      `USS_ADDR_RX_DATA:           rd_sel = fifo_top[7:0];
      `USS_ADDR_IRQ_ENABLE:        rd_sel = ien_q;
      `USS_ADDR_IRQ_FLAGS:         rd_sel = ifl_rd;
      default:                     rd_sel = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      rdata_q <= 8'h00;
    else
      rdata_q <= reg_rd ? rd_sel : 8'h00;
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Requests toward the core; registered to keep outputs glitch free
  logic irq_d;
  logic irq_q;
  logic wake_q;
  logic vec_q;

  assign irq_d = (rx_flag & ien_q[`USS_IEN_RX]) |
                 (tx_flag & ien_q[`USS_IEN_TX]);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
      vec_q  <= 1'b0;
    end else begin
      irq_q  <= irq_d;
      wake_q <= irq_d & ien_q[`USS_IEN_PERIPHERAL] & core_sleep;
      vec_q  <= irq_d & ien_q[`USS_IEN_PERIPHERAL] &
                ien_q[`USS_IEN_GLOBAL];
    end
  end

  assign irq_request        = irq_q;
  assign wake_request       = wake_q;
  assign irq_vector_request = vec_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_TX_FIRST_MOVES: assert property (
    wr_txd && tx_active && !hold_full_q && !tsr_full_q
    |=> hold_full_q ##1 (tsr_full_q && !hold_full_q && tx_cnt_q == 4'h0))
    else $error("first word did not move to shifter");

  AST_TX_RELOAD: assert property (
    tx_done && hold_full_q
    |=> tsr_full_q && !hold_full_q && tx_flag && tx_cnt_q == 4'h0)
    else $error("held word not reloaded after shift out");

  AST_TX_WRITE_CLEARS: assert property (
    wr_txd && tx_en && !hold_full_q && port_en |=> !tx_flag)
    else $error("transmit flag not cleared by write");

  AST_TX_WAKE: assert property (
    tx_flag && ien_q[`USS_IEN_TX] && ien_q[`USS_IEN_PERIPHERAL] &&
    core_sleep |=> wake_request)
    else $error("transmit flag did not wake");

  AST_RX_FLAG: assert property (
    rx_done && !fifo_full |=> rx_flag ##1
    (irq_request == ien_q[`USS_IEN_RX] || tx_flag))
    else $error("receive flag or request missing");

  // A pop or an enable write in the same cycle legally changes the outcome
  AST_RX_OVERRUN: assert property (
    rx_done && fifo_full && !fifo_pop && !wr_rcs
    |=> ovr_q && !rx_active && fifo_full)
    else $error("overrun not raised");

  AST_OVR_CLEAR: assert property (
    ovr_q && wr_rcs && !reg_wdata[`USS_RCS_CONT_RX_EN] |=> ##1 !ovr_q)
    else $error("overrun survived enable clear");

  AST_OE_TX_ONLY: assert property (
    serial_data_pin_oe |-> $past(slave_on && tx_mode))
    else $error("data driven outside slave transmit");

  AST_NO_SHIFT_OFF: assert property (
    !slave_on && $past(!slave_on) |-> rx_cnt_q == 4'h0 && !tsr_full_q)
    else $error("shifting outside slave mode");

  AST_BIT_ON_RISE: assert property (
    !ck_rise |=> $stable(serial_data_pin_out))
    else $error("data changed away from leading edge");

  CVR_TX_TWO: cover property (tx_done && hold_full_q);
  CVR_RX_SLEEP: cover property (core_sleep && fifo_push ##1 wake_request);
  CVR_OVERRUN: cover property (rx_done && fifo_full);
  CVR_RX_NINE: cover property (fifo_push && rx9_en);

endmodule

/* verification/uss_ext_master.sv */
// External synchronous master that clocks the serial slave
`timescale 1ns/1ps
module uss_ext_master #(
  parameter int HALF_NS = 24
) (
  output logic      serial_clock_pin,
  output logic      master_data,
  input  wire logic line_level
);
  initial begin
    serial_clock_pin = 1'b0;
    master_data      = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // One word, clock idle low outside it; gap stretches the low phase
  task automatic xfer(input logic [8:0] wdata, input int nbits,
                      input int gap, output logic [8:0] rdata);
    rdata = 9'h000;
    for (int i = 0; i < nbits; i++) begin
      serial_clock_pin = 1'b1;
      master_data      = wdata[i];
      #(HALF_NS);
      serial_clock_pin = 1'b0;
      rdata[i]         = line_level;
      #(HALF_NS + gap);
    end
    // Released line flips so a stale bit never passes for data
    master_data = ~master_data;
  endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the synchronous serial slave
`timescale 1ns/1ps
`include "uss_cfg.svh"
module tb;
  logic       ref_clk;
  logic       rstn;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       core_sleep;
  logic       sclk;
  logic       m_dat;
  logic       line_level;
  logic       dat_out;
  logic       dat_oe;
  logic       irq;
  logic       wake;
  logic       vec;
  logic [7:0] rv;
  logic [8:0] mrx;
  logic [8:0] w [4];
  int         seed = 64066;
  int         fails = 0;
  int         num_checks = 0;

  always #2 ref_clk = ~ref_clk;
  assign line_level = dat_oe ? dat_out : m_dat;

  uss_core dut_u (
    .ref_clk            (ref_clk),
    .rstn               (rstn),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .core_sleep         (core_sleep),
    .serial_clock_pin   (sclk),
    .serial_data_pin_in (line_level),
    .serial_data_pin_out(dat_out),
    .serial_data_pin_oe (dat_oe),
    .irq_request        (irq),
    .wake_request       (wake),
    .irq_vector_request (vec)
  );

  uss_ext_master m_u (
    .serial_clock_pin(sclk),
    .master_data     (m_dat),
    .line_level      (line_level)
  );

  ////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] flags_exp(input logic rxf,
                                           input logic txf);
    return {2'b00, rxf, txf, 4'h0};
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cmpb(input logic got, input logic exp, input string msg);
    cmp({7'h00, got}, {7'h00, exp}, msg);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] mask,
                       input logic [7:0] exp, input string msg);
    rd(a);
    cmp(rv & mask, exp, msg);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic summarize();
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is a few microseconds; this is ample
  initial begin
    #200000;
    fails++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0; rstn = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; core_sleep = 1'b0;
    settle(2);
    rstn <= 1'b1;
    rdchk(`USS_ADDR_RX_STATUS_CONTROL, 8'hff, 8'h00, "rcs reset");
    rdchk(`USS_ADDR_TX_STATUS_CONTROL, 8'hff, 8'h02, "tcs reset");
    wr(3'h6, 8'hff);
    rdchk(3'h6, 8'hff, 8'h00, "unmapped read");
    // Transmit setup: port still off, so no drive yet
    wr(`USS_ADDR_TX_STATUS_CONTROL, 8'h30);
    settle(3);
    cmpb(dat_oe, 1'b0, "drive with port off");
    wr(`USS_ADDR_RX_STATUS_CONTROL, 8'h80);
    settle(3);
    cmpb(dat_oe, 1'b1, "slave transmit drive");
    wr(`USS_ADDR_IRQ_ENABLE, 8'h50);
    for (int i = 0; i < 3; i++) w[i] = {1'b0, 8'($random(seed))};
    wr(`USS_ADDR_TX_DATA, w[0][7:0]);
    wr(`USS_ADDR_TX_DATA, w[1][7:0]);
    core_sleep <= 1'b1;
    settle(4);
    rdchk(`USS_ADDR_IRQ_FLAGS, 8'hff, flags_exp(0, 0), "txf held");
    rdchk(`USS_ADDR_TX_STATUS_CONTROL, 8'hff, 8'h30, "shifter full");
    cmpb(wake, 1'b0, "early wake");
    m_u.xfer(9'h000, 8, 0, mrx);
    cmp(mrx[7:0], w[0][7:0], "first word");
    settle(10);
    cmpb(wake, 1'b1, "tx wake");
    cmpb(vec, 1'b0, "vector without global");
    rdchk(`USS_ADDR_IRQ_FLAGS, 8'hff, flags_exp(0, 1), "txf set");
    core_sleep <= 1'b0;
    wr(`USS_ADDR_IRQ_ENABLE, 8'hd0);
    settle(3);
    cmpb(vec, 1'b1, "vector with global");
    wr(`USS_ADDR_TX_DATA, w[2][7:0]);
    settle(3);
    rdchk(`USS_ADDR_IRQ_FLAGS, 8'hff, flags_exp(0, 0), "txf cleared");
    m_u.xfer(9'h000, 8, 40, mrx);
    cmp(mrx[7:0], w[1][7:0], "held word, slow clock");
    m_u.xfer(9'h000, 8, 0, mrx);
    cmp(mrx[7:0], w[2][7:0], "third word");
    settle(10);
    rdchk(`USS_ADDR_TX_STATUS_CONTROL, 8'hff, 8'h32, "shifter empty");
    // Master clock source: not a slave, must not drive
    wr(`USS_ADDR_TX_STATUS_CONTROL, 8'hb0);
    settle(3);
    cmpb(dat_oe, 1'b0, "drive as master");
    // Receive, single enable set beside continuous
    wr(`USS_ADDR_TX_STATUS_CONTROL, 8'h10);
    wr(`USS_ADDR_RX_STATUS_CONTROL, 8'hb0);
    wr(`USS_ADDR_IRQ_ENABLE, 8'h60);
    settle(3);
    cmpb(dat_oe, 1'b0, "no drive in receive");
    for (int k = 0; k < 4; k++) begin
      if (k == 2) wr(`USS_ADDR_RX_STATUS_CONTROL, 8'hf0);
      w[k] = 9'($random(seed));
      if (k < 2) w[k][8] = 1'b0;
      core_sleep <= 1'b1;
      m_u.xfer(w[k], (k < 2) ? 8 : 9, k * 16, mrx);
      settle(10);
      cmpb(wake, 1'b1, "rx wake");
      cmpb(irq, 1'b1, "rx request");
      core_sleep <= 1'b0;
      rdchk(`USS_ADDR_IRQ_FLAGS, 8'hff, flags_exp(1, 0), "rxf");
      rd(`USS_ADDR_RX_STATUS_CONTROL);
      if (k >= 2) cmpb(rv[0], w[k][8], "ninth bit");
      rdchk(`USS_ADDR_RX_DATA, 8'hff, w[k][7:0], "rx word");
      settle(3);
      cmpb(irq, 1'b0, "request after drain");
    end
    // Overrun: third complete word is dropped and blocks the rest
    wr(`USS_ADDR_RX_STATUS_CONTROL, 8'h90);
    for (int j = 0; j < 3; j++) begin
      w[j] = {1'b0, 8'($random(seed))};
      m_u.xfer(w[j], 8, 0, mrx);
    end
    settle(10);
    rdchk(`USS_ADDR_RX_STATUS_CONTROL, 8'hfe, 8'h92, "overrun");
    m_u.xfer(9'h0a5, 8, 0, mrx);
    settle(10);
    rdchk(`USS_ADDR_RX_DATA, 8'hff, w[0][7:0], "kept first");
    rdchk(`USS_ADDR_RX_DATA, 8'hff, w[1][7:0], "kept second");
    settle(3);
    rdchk(`USS_ADDR_IRQ_FLAGS, 8'hff, flags_exp(0, 0), "blocked");
    wr(`USS_ADDR_RX_STATUS_CONTROL, 8'h80);
    rdchk(`USS_ADDR_RX_STATUS_CONTROL, 8'hfe, 8'h80, "overrun gone");
    wr(`USS_ADDR_RX_STATUS_CONTROL, 8'h90);
    w[3] = {1'b0, 8'($random(seed))};
    m_u.xfer(w[3], 8, 8, mrx);
    settle(10);
    rdchk(`USS_ADDR_RX_DATA, 8'hff, w[3][7:0], "receive resumes");
    summarize();
  end
endmodule
